// ===== src/pll_clock_gen_pkg.sv
// Purpose: Shared constants for the PLL clock generator control block
// Assumes: APB slave with 32-bit data, 8-bit register payloads
// Notes: Offsets are byte addresses, one aligned word per register
package pll_clock_gen_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BW = 8'h04;
  localparam logic [7:0] OFF_PROG = 8'h08;

  // ==========================================================
  // Control register field positions
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_LOCK_CHG = 6;
  localparam int CTRL_POWER = 5;
  localparam int CTRL_SRC_SEL = 4;
  localparam logic [3:0] CTRL_LOW_FILL = 4'hf;

  // ==========================================================
  // Bandwidth register field positions
  localparam int BW_AUTO = 7;
  localparam int BW_SETTLED = 6;
  localparam int BW_FILTER = 5;
  localparam int BW_XTAL_LOSS = 4;

  // ==========================================================
  // Programming register fields and reset values
  localparam int PROG_MULT_LSB = 4;
  localparam int PROG_RANGE_LSB = 0;
  localparam logic [3:0] MULT_RESET = 4'h6;
  localparam logic [3:0] RANGE_RESET = 4'h6;
  localparam logic [3:0] MULT_ONE = 4'h1;
  localparam logic [3:0] FIELD_ZERO = 4'h0;

  // ==========================================================
  // Source switch timing, counted in edges of the new source
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  // Source switch states
  typedef enum logic {
    SW_RUN,
    SW_HOLD
  } sw_state_t;

endpackage

// ===== src/pll_clock_gen_control.sv
// Purpose: Control, status and base clock selection of a PLL clock generator
// Assumes: clk at 100 MHz, much faster than xtal_clk and vco_clk
// Notes: Source clocks are sampled, so base_clk_out is a divided replica
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Base clock is selected source divided by two
// - Oscillator and PLL run only with enable
// - Settled change sets flag; irq when enabled
// - Manual mode forces irq enable to zero
// - Manual mode: flag and settled read zero
// - PLL off or range zero forces select zero
// - Programming register read-only while powered
// - VCO selected keeps power bit set
// - Reading control register clears change flag
// - Reset clears bits, sets power bit and both programming fields to 6
// - Output held static during source switch
// - Stop clears source select
// - Select one is VCO, zero crystal
// - Control register low nibble reads ones
// - Automatic mode: settled flag read-only status
// - Filter bit reports or sets tracking state
// - Manual filter value kept across automatic mode
// - Mode bit one automatic, zero manual
// - Crystal loss check by write then read
// - Crystal loss reads zero with crystal source
// - Zero multiplier acts as one
module pll_clock_gen_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pll_clock_gen_pkg::ADDR_W-1:0] paddr,
  input wire logic [pll_clock_gen_pkg::DATA_W-1:0] pwdata,
  output logic pready,
  output logic [pll_clock_gen_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  // Source clocks and analog detector, asynchronous
  input wire logic xtal_clk,
  input wire logic vco_clk,
  input wire logic settled_in,
  input wire logic tracking_in,
  // System integration side
  input wire logic osc_enable_in,
  output logic base_clk_out,
  output logic pll_irq_out,
  // Analog PLL control
  output logic pll_run_out,
  output logic filter_track_out,
  output logic [3:0] feedback_mult_out,
  output logic [3:0] range_mult_out
);

  // ==========================================================
  // State
  typedef struct packed {
    // Crystal, VCO and detector synchronisers
    logic x_s1;
    logic x_s2;
    logic x_d;
    logic v_s1;
    logic v_s2;
    logic v_d;
    logic lk_s1;
    logic lk_s2;
    logic lk_d;
    logic tr_s1;
    logic tr_s2;
    // Control register bits
    logic irq_enable_bit;
    logic lock_change_flag;
    logic pll_power_bit;
    logic base_src_select;
    // Bandwidth register bits, manual filter kept aside
    logic self_bw_mode_bit;
    logic manual_filter;
    logic xtal_loss_bit;
    // Programming register fields
    logic [3:0] feedback_mult_field;
    logic [3:0] range_mult_field;
    // Source switch and divider
    pll_clock_gen_pkg::sw_state_t sw_state;
    logic [1:0] sw_cnt;
    logic active_src;
    logic base_clk;
    // Registered outputs towards the PLL and the system
    logic irq;
    logic pll_run;
    logic filter_track;
    logic [3:0] eff_mult;
    logic [3:0] range_out;
    // Bus answer
    logic ready;
    logic [31:0] rdata;
    logic slverr;
  } state_t;

  state_t r;
  state_t next_r;

  // Decode helpers
  // Address hits and transfer strobes
  logic hit_ctrl;
  logic hit_bw;
  logic hit_prog;
  logic done;
  logic wr;
  logic rd;

  // Synchronised rising edges of the sources
  logic x_edge;
  logic v_edge;
  logic new_edge;
  logic old_edge;

  // Readback words
  logic settled_rd;
  logic filter_rd;
  logic [7:0] ctrl_val;
  logic [7:0] bw_val;
  logic [7:0] prog_val;

  // ==========================================================
  // Next state logic
  always_comb begin
    next_r = r;

    // Two-stage synchronisers, third stage for edge detection
    next_r.x_s1 = xtal_clk;
    next_r.x_s2 = r.x_s1;
    next_r.x_d = r.x_s2;
    next_r.v_s1 = vco_clk;
    next_r.v_s2 = r.v_s1;
    next_r.v_d = r.v_s2;

    // Detector levels, lock also delayed for change detection
    next_r.lk_s1 = settled_in;
    next_r.lk_s2 = r.lk_s1;
    next_r.lk_d = r.lk_s2;
    next_r.tr_s1 = tracking_in;
    next_r.tr_s2 = r.tr_s1;

    // Edge detect reads only the second stage and its delay
    x_edge = r.x_s2 & ~r.x_d;
    v_edge = r.v_s2 & ~r.v_d;

    // Bus phase decode; completion is the cycle pready is high
    hit_ctrl = (paddr == pll_clock_gen_pkg::OFF_CTRL);
    hit_bw = (paddr == pll_clock_gen_pkg::OFF_BW);
    hit_prog = (paddr == pll_clock_gen_pkg::OFF_PROG);
    done = psel & penable & r.ready;
    wr = done & pwrite;
    rd = done & ~pwrite;

    // Readback values
    settled_rd = r.self_bw_mode_bit & r.lk_s2;
    filter_rd = r.self_bw_mode_bit ? r.tr_s2 : r.manual_filter;
    ctrl_val = {r.irq_enable_bit,
                r.lock_change_flag & r.self_bw_mode_bit,
                r.pll_power_bit,
                r.base_src_select,
                pll_clock_gen_pkg::CTRL_LOW_FILL};
    bw_val = {r.self_bw_mode_bit, settled_rd, filter_rd,
              r.xtal_loss_bit & r.base_src_select,
              4'h0};
    prog_val = {r.feedback_mult_field, r.range_mult_field};

    // One wait state: data is prepared, then pready rises
    next_r.ready = psel & penable & ~r.ready;
    if (psel && penable && !r.ready) begin
      next_r.slverr = ~(hit_ctrl | hit_bw | hit_prog);
      if (pwrite || !(hit_ctrl | hit_bw | hit_prog)) begin
        next_r.rdata = 32'h0000_0000;
      end else if (hit_ctrl) begin
        next_r.rdata = {24'h00_0000, ctrl_val};
      end else if (hit_bw) begin
        next_r.rdata = {24'h00_0000, bw_val};
      end else begin
        next_r.rdata = {24'h00_0000, prog_val};
      end
    end else begin
      next_r.slverr = 1'b0;
    end

    // Control register write, interlocks use the old bits
    if (wr && hit_ctrl) begin
      next_r.irq_enable_bit =
        pwdata[pll_clock_gen_pkg::CTRL_IRQ_EN]; // below
      if (!r.base_src_select) begin
        next_r.pll_power_bit =
          pwdata[pll_clock_gen_pkg::CTRL_POWER];
      end
      if (r.pll_power_bit) begin
        next_r.base_src_select =
          pwdata[pll_clock_gen_pkg::CTRL_SRC_SEL];
      end else begin
        next_r.base_src_select = 1'b0;
      end
    end

    // Bandwidth register write; settled bit is not stored
    if (wr && hit_bw) begin
      next_r.self_bw_mode_bit =
        pwdata[pll_clock_gen_pkg::BW_AUTO];
      if (!r.self_bw_mode_bit) begin
        next_r.manual_filter =
          pwdata[pll_clock_gen_pkg::BW_FILTER];
      end
    end

    // Programming register write, locked while powered
    if (wr && hit_prog && !r.pll_power_bit) begin
      next_r.feedback_mult_field =
        pwdata[pll_clock_gen_pkg::PROG_MULT_LSB +: 4];
      next_r.range_mult_field =
        pwdata[pll_clock_gen_pkg::PROG_RANGE_LSB +: 4];
    end

    // Crystal loss: a crystal edge clears, a write of one re-arms
    if (x_edge) begin
      next_r.xtal_loss_bit = 1'b0;
    end
    if (wr && hit_bw && pwdata[pll_clock_gen_pkg::BW_XTAL_LOSS]) begin
      next_r.xtal_loss_bit = 1'b1;
    end

    // Forced values after all writes
    // Applied last so no write can bypass an interlock
    if (!next_r.self_bw_mode_bit) begin
      next_r.irq_enable_bit = 1'b0;
    end
    if (!next_r.pll_power_bit ||
        next_r.range_mult_field == pll_clock_gen_pkg::FIELD_ZERO) begin
      next_r.base_src_select = 1'b0;
    end
    if (!osc_enable_in) begin
      next_r.base_src_select = 1'b0;
    end
    if (!next_r.base_src_select) begin
      next_r.xtal_loss_bit = 1'b0;
    end

    // Change flag: read clears, a settled change sets and wins
    if (rd && hit_ctrl) begin
      next_r.lock_change_flag = 1'b0;
    end
    if (r.lk_s2 != r.lk_d && r.self_bw_mode_bit) begin
      next_r.lock_change_flag = 1'b1;
    end
    if (!r.self_bw_mode_bit) begin
      next_r.lock_change_flag = 1'b0;
    end

    // Glitch-free source switch and divide by two
    // The divider only toggles on edges of the active source.
    // On a select change the output freezes at its level and the
    // new source must show its edges before it takes over, so no
    // short pulse can reach the base clock.
    new_edge = r.base_src_select ? v_edge : x_edge;
    old_edge = r.active_src ? v_edge : x_edge;
    case (r.sw_state)
      pll_clock_gen_pkg::SW_RUN: begin
        if (r.base_src_select != r.active_src) begin
          next_r.sw_state = pll_clock_gen_pkg::SW_HOLD;
          next_r.sw_cnt = 2'h0;
        end else if (old_edge) begin
          next_r.base_clk = ~r.base_clk;
        end
      end
      pll_clock_gen_pkg::SW_HOLD: begin
        if (r.base_src_select == r.active_src) begin
          next_r.sw_state = pll_clock_gen_pkg::SW_RUN;
        end else if (new_edge) begin
          if (r.sw_cnt == pll_clock_gen_pkg::SWITCH_EDGES - 2'h1) begin
            next_r.active_src = r.base_src_select;
            next_r.sw_state = pll_clock_gen_pkg::SW_RUN;
          end else begin
            next_r.sw_cnt = r.sw_cnt + 2'h1;
          end
        end
      end
      default: begin
        next_r.sw_state = pll_clock_gen_pkg::SW_RUN;
      end
    endcase
    if (!osc_enable_in) begin
      next_r.base_clk = 1'b0;
    end

    // Registered outputs
    next_r.irq = osc_enable_in & next_r.lock_change_flag &
                 next_r.irq_enable_bit;
    next_r.pll_run = osc_enable_in & next_r.pll_power_bit &
      (next_r.range_mult_field != pll_clock_gen_pkg::FIELD_ZERO);
    next_r.filter_track = next_r.self_bw_mode_bit ? r.tr_s2 :
                          next_r.manual_filter;
    next_r.eff_mult =
      (next_r.feedback_mult_field == pll_clock_gen_pkg::FIELD_ZERO) ?
      pll_clock_gen_pkg::MULT_ONE : next_r.feedback_mult_field;
    next_r.range_out = next_r.range_mult_field;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Everything clear except power, programming fields and their outputs
      r <= '0;
      // Power on so the loop settles during start-up
      r.pll_power_bit <= 1'b1;
      r.feedback_mult_field <= pll_clock_gen_pkg::MULT_RESET;
      r.range_mult_field <= pll_clock_gen_pkg::RANGE_RESET;
      r.sw_state <= pll_clock_gen_pkg::SW_RUN;
      r.eff_mult <= pll_clock_gen_pkg::MULT_RESET;
      r.range_out <= pll_clock_gen_pkg::RANGE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  // Bus answer
  assign pready = r.ready;
  assign prdata = r.rdata;
  assign pslverr = r.slverr;

  // Clock and interrupt towards the system
  assign base_clk_out = r.base_clk;
  assign pll_irq_out = r.irq;

  // Analog PLL control
  assign pll_run_out = r.pll_run;
  assign filter_track_out = r.filter_track;
  assign feedback_mult_out = r.eff_mult;
  assign range_mult_out = r.range_out;

endmodule

`default_nettype wire

// ===== verif/pll_clock_gen_control_monitor.sv
// Purpose: Concurrent checks on the PLL clock control ports
// Assumes: Bound to every instance of the control block
// Notes: One clock domain, so default clocking is used
`timescale 1ns/1ns
`default_nettype none
module pll_clock_gen_control_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pll_clock_gen_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic [pll_clock_gen_pkg::DATA_W-1:0] prdata,
  input wire logic pslverr,
  // Clock and PLL side
  input wire logic osc_enable_in,
  input wire logic base_clk_out,
  input wire logic pll_irq_out,
  input wire logic pll_run_out,
  input wire logic [3:0] feedback_mult_out,
  input wire logic [3:0] range_mult_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Completed transfer to one offset
  sequence s_acc(logic [7:0] off);
    psel && penable && pready && paddr == off;
  endsequence
  // ==========================================================
  // Checks
  chk_stop_low: assert property (!osc_enable_in |=>
    !base_clk_out && !pll_irq_out && !pll_run_out)
    else $error("outputs not low while stopped");
  chk_run_range: assert property (pll_run_out |->
    range_mult_out != 4'h0 && $past(osc_enable_in))
    else $error("PLL runs with zero range or no enable");
  chk_mult_one: assert property (feedback_mult_out != 4'h0)
    else $error("zero multiplier reached the PLL");
  chk_prog_locked: assert property (
    s_acc(pll_clock_gen_pkg::OFF_PROG) ##0 pwrite ##1 pll_run_out
    |-> $stable({range_mult_out, feedback_mult_out})[*2])
    else $error("programming changed while powered");
  chk_ctrl_fill: assert property (
    s_acc(pll_clock_gen_pkg::OFF_CTRL) ##0 !pwrite
    |-> prdata == {24'h0, prdata[7:4], 4'hf})
    else $error("control low bits not read as ones");
  chk_manual_zero: assert property (
    s_acc(pll_clock_gen_pkg::OFF_BW) ##0 !pwrite && !prdata[7]
    |-> !prdata[6] && prdata[3:0] == 4'h0)
    else $error("settled bit set in manual mode");
  chk_clk_hold: assert property ($changed(base_clk_out) |=>
    ($stable(base_clk_out) || !$past(osc_enable_in))[*3])
    else $error("base clock phase too short");
  chk_unmapped: assert property (s_acc(8'h0c) |->
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule

bind pll_clock_gen_control pll_clock_gen_control_monitor mon (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
  .pslverr, .osc_enable_in, .base_clk_out, .pll_irq_out, .pll_run_out,
  .feedback_mult_out, .range_mult_out);
`default_nettype wire

// ===== verif/pll_far_side_model.sv
// Purpose: Source clocks, lock detector and enable seen by the block
// Assumes: Bench requests stop, lock, tracking and crystal failure
// Notes: Crystal period 16 clk cycles, VCO period 8 clk cycles
`timescale 1ns/1ns
`default_nettype none
module pll_far_side_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench requests
  input wire logic stop_req,
  input wire logic xtal_dead,
  input wire logic lock_req,
  input wire logic track_req,
  // Block side
  input wire logic pll_run_out,
  output logic osc_enable_in,
  output logic xtal_clk,
  output logic vco_clk,
  output logic settled_in,
  output logic tracking_in
);
  logic [3:0] cnt;
  // ==========================================================
  // Free count paces both sources
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end
  // Sources run only while enabled
  always_comb begin
    osc_enable_in = !stop_req;
    xtal_clk = osc_enable_in && !xtal_dead && cnt[3];
    vco_clk = osc_enable_in && pll_run_out && cnt[2];
    settled_in = lock_req && pll_run_out;
    tracking_in = track_req;
  end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the PLL clock generator control
// Assumes: APB slave answers after a bounded wait
// Notes: Base clock phase is 16 clk on crystal, 8 clk on VCO
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ==========================================================
  // Signals
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic xtal_clk, vco_clk, settled_in, tracking_in, osc_enable_in;
  logic base_clk_out, pll_irq_out, pll_run_out, filter_track_out;
  logic stop_req, xtal_dead, lock_req, track_req;
  logic [3:0] feedback_mult_out, range_mult_out;
  int err_count, num_checks;
  // Block and its far side
  pll_clock_gen_control dut (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .xtal_clk, .vco_clk,
    .settled_in, .tracking_in, .osc_enable_in, .base_clk_out,
    .pll_irq_out, .pll_run_out, .filter_track_out, .feedback_mult_out,
    .range_mult_out);
  pll_far_side_model far (.clk, .rst_n, .stop_req, .xtal_dead,
    .lock_req, .track_req, .pll_run_out, .osc_enable_in, .xtal_clk,
    .vco_clk, .settled_in, .tracking_in);
  // Clock source
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Compare, bus and measuring tasks
  task automatic ck(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) ck("pready", 32'(pready), 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    ck($sformatf("reg %h", a), q, e);
  endtask
  task automatic half(input int e);
    logic b;
    int n;
    for (int i = 0; i < 2; i++) begin
      b = base_clk_out;
      n = 0;
      while (base_clk_out === b && n < 100) begin
        @(posedge clk);
        n++;
      end
    end
    ck("base phase", 32'(n), 32'(e));
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  // ==========================================================
  // Test sequence
  initial begin
    {rst_n, psel, penable, pwrite, stop_req, xtal_dead} = 6'h0;
    {lock_req, track_req, paddr, pwdata} = 42'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h00, 32'h2f);
    rc(8'h04, 32'h00);
    wr(8'h08, 8'h05);
    rc(8'h08, 32'h66);
    wr(8'h00, 8'ha0);
    rc(8'h00, 32'h2f);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h30);
    rc(8'h00, 32'h3f);
    half(8);
    wr(8'h00, 8'h10);
    rc(8'h00, 32'h3f);
    xtal_dead <= 1'b1;
    wr(8'h04, 8'h10);
    repeat (24) @(posedge clk);
    rc(8'h04, 32'h10);
    xtal_dead <= 1'b0;
    wr(8'h04, 8'h10);
    repeat (24) @(posedge clk);
    rc(8'h04, 32'h00);
    stop_req <= 1'b1;
    repeat (8) @(posedge clk);
    stop_req <= 1'b0;
    rc(8'h00, 32'h2f);
    half(16);
    xtal_dead <= 1'b1;
    wr(8'h04, 8'h10);
    rc(8'h04, 32'h00);
    xtal_dead <= 1'b0;
    wr(8'h00, 8'h00);
    rc(8'h00, 32'h0f);
    wr(8'h00, 8'h30);
    rc(8'h00, 32'h2f);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h00);
    rc(8'h08, 32'h00);
    ck("mult", 32'(feedback_mult_out), 32'h1);
    ck("range", 32'(range_mult_out), 32'h0);
    wr(8'h00, 8'h20);
    wr(8'h00, 8'h30);
    rc(8'h00, 32'h2f);
    ck("run", 32'(pll_run_out), 32'h0);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h66);
    wr(8'h04, 8'h20);
    rc(8'h04, 32'h20);
    wr(8'h04, 8'ha0);
    wr(8'h00, 8'ha0);
    rc(8'h04, 32'h80);
    rc(8'h00, 32'haf);
    lock_req <= 1'b1;
    repeat (10) @(posedge clk);
    ck("irq", 32'(pll_irq_out), 32'h1);
    rc(8'h0c, 32'h00);
    rc(8'h00, 32'hef);
    rc(8'h00, 32'haf);
    repeat (2) @(posedge clk);
    ck("irq", 32'(pll_irq_out), 32'h0);
    track_req <= 1'b1;
    repeat (10) @(posedge clk);
    rc(8'h04, 32'he0);
    ck("track", 32'(filter_track_out), 32'h1);
    wr(8'h04, 8'h00);
    rc(8'h04, 32'h20);
    rc(8'h00, 32'h2f);
    end_sim();
  end
endmodule
`default_nettype wire
